// File: design/ebi_bus.sv
// External memory bus interface: mode and wait registers, bus cycle
// sequencer and pin sharing for ports 4 to 6.
// Assumes one request per CPU bus cycle, held until cpu_done, and a
// system decode that flags internal ROM, RAM and SFR addresses.
`timescale 1ns/1ps
`default_nettype none
module ebi_bus (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // CPU bus cycle request
  input  wire logic               cpu_req,
  input  wire logic [15:0]        cpu_addr,
  input  wire logic               cpu_we,
  input  wire logic               cpu_bit_op,
  input  wire logic [2:0]         cpu_bit_sel,
  input  wire logic [7:0]         cpu_wdata,
  input  wire logic               cpu_int_hit,
  input  wire logic               main_crystal_clock,
  output logic                    cpu_ready,
  output logic                    cpu_done,
  output logic [7:0]              cpu_rdata_q,
  // Port block side
  input  wire ebi_pkg::ebi_pins_t port_out,
  input  wire ebi_pkg::ebi_pins_t port_oe,
  // Pads
  input  wire ebi_pkg::ebi_pins_t pad_in,
  output logic [23:0]             pad_out,
  output logic [23:0]             pad_oe
);

  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  logic [2:0]          window_code_q;
  logic [1:0]          wait_code_q;
  ebi_pkg::ebi_state_t st_q;
  logic [15:0]         addr_q;
  logic [7:0]          wdata_q;
  logic                we_q;
  logic                ext_q;
  logic                mode_hit;
  logic                wait_hit;
  logic                taken;
  logic                expansion_on;
  logic [7:0]          upper_mask;
  logic [7:0]          mode_wr_val;
  logic [7:0]          wait_wr_val;
  logic                ext_wait;
  logic                wait_pin_n;
  logic                rd_strobe_n;
  logic                wr_strobe_n;
  logic                addr_latch_strobe;
  ebi_pkg::ebi_pins_t  sel;
  ebi_pkg::ebi_pins_t  bus_out;
  ebi_pkg::ebi_pins_t  bus_oe;

  assign mode_hit  = (cpu_addr == ebi_pkg::EXPANSION_MODE_SELECT_ADDR);
  assign wait_hit  = (cpu_addr == ebi_pkg::WAIT_SETTING_ADDR);
  assign cpu_ready = (st_q == ebi_pkg::EBI_ST_IDLE);
  assign taken     = cpu_req && cpu_ready;
  assign cpu_done  = (st_q == ebi_pkg::EBI_ST_DONE);

  // legal window codes only; a prohibited code leaves the pins as ports
  always_comb begin
    expansion_on = main_crystal_clock;
    upper_mask   = 8'h00;
    unique case (window_code_q)
      ebi_pkg::EBI_WIN_256B: upper_mask = 8'h00;
      ebi_pkg::EBI_WIN_4K:   upper_mask = 8'h0F;
      ebi_pkg::EBI_WIN_16K:  upper_mask = 8'h3F;
      ebi_pkg::EBI_WIN_FULL: upper_mask = 8'hFF;
      default:               expansion_on = 1'b0;
    endcase
  end

  // Bit writes alter one bit of the current value, byte writes replace it
  always_comb begin
    mode_wr_val = {5'h00, window_code_q};
    wait_wr_val = {2'h0, wait_code_q, 4'h0};
    if (cpu_bit_op) begin
      mode_wr_val[cpu_bit_sel] = cpu_wdata[0];
      wait_wr_val[cpu_bit_sel] = cpu_wdata[0];
    end else begin
      mode_wr_val = cpu_wdata;
      wait_wr_val = cpu_wdata;
    end
  end

  // bit and byte writes, upper bits not stored
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      window_code_q <= ebi_pkg::EXPANSION_MODE_RST[2:0];
    end else if (taken && cpu_we && mode_hit) begin
      window_code_q <= mode_wr_val[ebi_pkg::WINDOW_CODE_LSB +: ebi_pkg::WINDOW_CODE_W];
    end
  end

  // wait code storage, prohibited code behaves as one wait
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_code_q <= ebi_pkg::WAIT_SETTING_RST[5:4];
    end else if (taken && cpu_we && wait_hit) begin
      wait_code_q <= wait_wr_val[ebi_pkg::WAIT_CODE_LSB +: ebi_pkg::WAIT_CODE_W];
    end
  end

  // ----------------------------------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------------------------------
  // route only non-internal addresses outward
  // no external cycle without the crystal clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_q  <= 16'h0000;
      wdata_q <= 8'h00;
      we_q    <= 1'b0;
      ext_q   <= 1'b0;
    end else if (taken) begin
      addr_q  <= cpu_addr;
      wdata_q <= cpu_wdata;
      we_q    <= cpu_we;
      ext_q   <= expansion_on && !cpu_int_hit && !mode_hit && !wait_hit;
    end
  end

  // wait pin only counts on external cycles in pin-controlled mode
  assign wait_pin_n = pad_in.p6[ebi_pkg::P6_WAIT_INPUT];
  assign ext_wait   = ext_q && (wait_code_q == ebi_pkg::EBI_WAIT_PIN);

  // One address phase, one strobe phase, optional waits, one done cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= ebi_pkg::EBI_ST_IDLE;
    end else begin
      unique case (st_q)
        ebi_pkg::EBI_ST_IDLE: if (taken) st_q <= ebi_pkg::EBI_ST_ADDR;
        ebi_pkg::EBI_ST_ADDR: st_q <= ebi_pkg::EBI_ST_STRB;
        ebi_pkg::EBI_ST_STRB: begin
          if (ext_q && (wait_code_q == ebi_pkg::EBI_WAIT_ONE || wait_code_q == ebi_pkg::EBI_WAIT_BAD)) begin
            st_q <= ebi_pkg::EBI_ST_WAIT;
          end else if (ext_wait && !wait_pin_n) begin
            st_q <= ebi_pkg::EBI_ST_STRB;
          end else begin
            st_q <= ebi_pkg::EBI_ST_DONE;
          end
        end
        ebi_pkg::EBI_ST_WAIT: st_q <= ebi_pkg::EBI_ST_DONE;
        ebi_pkg::EBI_ST_DONE: st_q <= ebi_pkg::EBI_ST_IDLE;
        default:              st_q <= ebi_pkg::EBI_ST_IDLE;
      endcase
    end
  end

  // Read data is caught on the last strobe cycle so it is stable in done
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpu_rdata_q <= 8'h00;
    end else if ((st_q == ebi_pkg::EBI_ST_STRB || st_q == ebi_pkg::EBI_ST_WAIT) && !we_q) begin
      if (addr_q == ebi_pkg::EXPANSION_MODE_SELECT_ADDR) begin
        cpu_rdata_q <= {5'h00, window_code_q};
      end else if (addr_q == ebi_pkg::WAIT_SETTING_ADDR) begin
        cpu_rdata_q <= {2'h0, wait_code_q, 4'h0};
      end else begin
        cpu_rdata_q <= pad_in.p4;
      end
    end
  end

  // ----------------------------------------------------------------
  // Strobes and pin drive
  // ----------------------------------------------------------------
  // read and write strobes only on external cycles; address strobe on every bus cycle
  assign rd_strobe_n       = !(ext_q && !we_q && (st_q == ebi_pkg::EBI_ST_STRB || st_q == ebi_pkg::EBI_ST_WAIT));
  assign wr_strobe_n       = !(ext_q && we_q && (st_q == ebi_pkg::EBI_ST_STRB || st_q == ebi_pkg::EBI_ST_WAIT));
  assign addr_latch_strobe = (st_q == ebi_pkg::EBI_ST_ADDR);

  // unused upper pins fall back to the port
  // wait pin is a port unless pin-controlled waits are chosen
  // low address held through the address strobe so it can be latched
  always_comb begin
    sel     = '0;
    bus_out = '0;
    bus_oe  = '0;
    if (expansion_on) begin
      sel.p4 = 8'hFF;
      sel.p5 = upper_mask;
      sel.p6[ebi_pkg::P6_READ_STROBE]  = 1'b1;
      sel.p6[ebi_pkg::P6_WRITE_STROBE] = 1'b1;
      sel.p6[ebi_pkg::P6_ADDR_STROBE]  = 1'b1;
      sel.p6[ebi_pkg::P6_WAIT_INPUT]   = (wait_code_q == ebi_pkg::EBI_WAIT_PIN);
    end
    bus_out.p4 = (st_q == ebi_pkg::EBI_ST_ADDR || !we_q) ? addr_q[7:0] : wdata_q;
    bus_oe.p4  = (st_q == ebi_pkg::EBI_ST_ADDR) ? 8'hFF : {8{we_q && st_q != ebi_pkg::EBI_ST_IDLE}};
    bus_out.p5 = addr_q[15:8];
    bus_oe.p5  = 8'hFF;
    bus_out.p6[ebi_pkg::P6_READ_STROBE]  = rd_strobe_n;
    bus_out.p6[ebi_pkg::P6_WRITE_STROBE] = wr_strobe_n;
    bus_out.p6[ebi_pkg::P6_ADDR_STROBE]  = addr_latch_strobe;
    bus_oe.p6[ebi_pkg::P6_READ_STROBE]   = 1'b1;
    bus_oe.p6[ebi_pkg::P6_WRITE_STROBE]  = 1'b1;
    bus_oe.p6[ebi_pkg::P6_ADDR_STROBE]   = 1'b1;
  end

  ebi_pin_mux i_ebi_pin_mux (
    .sel      (sel),
    .bus_out  (bus_out),
    .bus_oe   (bus_oe),
    .port_out (port_out),
    .port_oe  (port_oe),
    .pad_out  (pad_out),
    .pad_oe   (pad_oe)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_ROUTE_OUT: assert property (
    taken && !cpu_we && expansion_on && !cpu_int_hit && !mode_hit && !wait_hit
      |-> ##2 !rd_strobe_n) else $error("external read gave no read strobe");

  AST_CRYSTAL_ONLY: assert property (
    taken && !main_crystal_clock |=> !ext_q) else $error("external cycle without crystal clock");

  AST_P4_ADDR: assert property (
    expansion_on && st_q == ebi_pkg::EBI_ST_ADDR |-> pad_out[7:0] == addr_q[7:0] && pad_oe[7:0] == 8'hFF)
    else $error("low address missing in address phase");

  AST_WAIT_PORT: assert property (
    wait_code_q != ebi_pkg::EBI_WAIT_PIN |-> pad_oe[22] == port_oe.p6[6] && pad_out[22] == port_out.p6[6])
    else $error("wait pin not left to the port");

  // Top address pins belong to the port in every mode but full address
  AST_UPPER_PORT: assert property (
    (window_code_q != ebi_pkg::EBI_WIN_FULL || !main_crystal_clock)
      |-> pad_oe[15:14] == port_oe.p5[7:6] && pad_out[15:14] == port_out.p5[7:6])
    else $error("unused upper pin taken from port");

  AST_FULL_ADDR: assert property (
    expansion_on && window_code_q == ebi_pkg::EBI_WIN_FULL && st_q == ebi_pkg::EBI_ST_ADDR
      |-> pad_out[15:8] == addr_q[15:8] && pad_oe[15:8] == 8'hFF) else $error("full address not driven");

  AST_MODE_READ: assert property (
    cpu_done && addr_q == ebi_pkg::EXPANSION_MODE_SELECT_ADDR && !we_q |-> cpu_rdata_q[7:3] == 5'h00)
    else $error("mode register upper bits not zero");

  AST_ONE_WAIT: assert property (
    st_q == ebi_pkg::EBI_ST_STRB && ext_q && wait_code_q == ebi_pkg::EBI_WAIT_ONE
      |=> st_q == ebi_pkg::EBI_ST_WAIT ##1 st_q == ebi_pkg::EBI_ST_DONE) else $error("one wait not inserted");

  AST_INT_STROBES: assert property (
    !ext_q |-> rd_strobe_n && wr_strobe_n) else $error("strobe on internal cycle");

  AST_INT_NOWAIT: assert property (
    st_q == ebi_pkg::EBI_ST_STRB && !ext_q |=> st_q == ebi_pkg::EBI_ST_DONE) else $error("internal cycle stretched");

  AST_LATCH_PULSE: assert property (
    taken |=> addr_latch_strobe ##1 !addr_latch_strobe) else $error("address strobe not pulsed");

endmodule : ebi_bus
`default_nettype wire

// File: design/ebi_pkg.sv
// External memory bus interface: shared constants, codes and pin carriers.
// Assumes a 16-bit CPU address space with byte-wide data.
package ebi_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] EXPANSION_MODE_SELECT_ADDR = 16'hFF47;
  localparam logic [15:0] WAIT_SETTING_ADDR          = 16'hFFF8;
  localparam logic [7:0]  EXPANSION_MODE_RST         = 8'h00;
  localparam logic [7:0]  WAIT_SETTING_RST           = 8'h10;
  localparam int          WINDOW_CODE_LSB            = 0;
  localparam int          WINDOW_CODE_W              = 3;
  localparam int          WAIT_CODE_LSB              = 4;
  localparam int          WAIT_CODE_W                = 2;

  // ----------------------------------------------------------------
  // Pin positions on port 6
  // ----------------------------------------------------------------
  localparam int P6_READ_STROBE  = 4;
  localparam int P6_WRITE_STROBE = 5;
  localparam int P6_WAIT_INPUT   = 6;
  localparam int P6_ADDR_STROBE  = 7;

  // Window codes
  typedef enum logic [2:0] {
    EBI_SINGLE_CHIP = 3'h0,
    EBI_WIN_256B    = 3'h3,
    EBI_WIN_4K      = 3'h4,
    EBI_WIN_16K     = 3'h5,
    EBI_WIN_FULL    = 3'h7
  } ebi_window_t;

  // Wait codes
  typedef enum logic [1:0] {
    EBI_WAIT_NONE = 2'h0,
    EBI_WAIT_ONE  = 2'h1,
    EBI_WAIT_BAD  = 2'h2,
    EBI_WAIT_PIN  = 2'h3
  } ebi_wait_t;

  // Bus cycle sequencer
  typedef enum logic [2:0] {
    EBI_ST_IDLE = 3'h0,
    EBI_ST_ADDR = 3'h1,
    EBI_ST_STRB = 3'h2,
    EBI_ST_WAIT = 3'h3,
    EBI_ST_DONE = 3'h4
  } ebi_state_t;

  // One byte per port 4, 5 and 6
  typedef struct packed {
    logic [7:0] p6;
    logic [7:0] p5;
    logic [7:0] p4;
  } ebi_pins_t;

endpackage : ebi_pkg

// File: design/ebi_pin_mux.sv
// Per-pin selection between the bus function and the general port.
// Assumes port latches and directions come from the port block.
`timescale 1ns/1ps
`default_nettype none
module ebi_pin_mux (
  // Selection
  input  wire ebi_pkg::ebi_pins_t sel,
  // Bus function side
  input  wire ebi_pkg::ebi_pins_t bus_out,
  input  wire ebi_pkg::ebi_pins_t bus_oe,
  // Port side
  input  wire ebi_pkg::ebi_pins_t port_out,
  input  wire ebi_pkg::ebi_pins_t port_oe,
  // Pads
  output logic [23:0]             pad_out,
  output logic [23:0]             pad_oe
);

  // ----------------------------------------------------------------
  // One mux per pin
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 24; i++) begin : g_pin
      assign pad_out[i] = sel[i] ? bus_out[i] : port_out[i];
      assign pad_oe[i]  = sel[i] ? bus_oe[i]  : port_oe[i];
    end
  endgenerate

endmodule : ebi_pin_mux
`default_nettype wire

// File: sim/ebi_ext_mem.sv
// External memory model hung on ports 4 to 6 of the bus block.
// Assumes the pad bit layout of the bus block and the single ref_clk domain.
`timescale 1ns/1ps
`default_nettype none
module ebi_ext_mem (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Pads seen from outside
  input  wire logic [23:0]        pad_out,
  input  wire logic [23:0]        pad_oe,
  input  wire logic [3:0]         wait_cycles,
  output var  ebi_pkg::ebi_pins_t pad_in,
  // Observation
  output logic [7:0]              lat_lo,
  output logic [7:0]              lat_hi,
  output logic [7:0]              lat_hi_oe,
  output logic [7:0]              rd_cnt,
  output logic [7:0]              wr_cnt,
  output logic [7:0]              addr_latch_cnt
);
  logic [7:0] mem [0:255];
  logic [7:0] last_q;
  logic [3:0] strb_q;
  logic [2:0] prev_q;
  logic       rd_low;
  logic       wr_low;
  logic       addr_latch_strobe;

  assign rd_low            = ~pad_out[20] & pad_oe[20];
  assign wr_low            = ~pad_out[21] & pad_oe[21];
  assign addr_latch_strobe = pad_out[23] & pad_oe[23];

  // address latch
  // Sampled while the strobe is high, so it is what stands at its fall
  always_ff @(posedge ref_clk) begin
    if (addr_latch_strobe) begin
      lat_lo    <= pad_out[7:0];
      lat_hi    <= pad_out[15:8];
      lat_hi_oe <= pad_oe[15:8];
    end
    if (wr_low) begin
      mem[lat_lo] <= pad_out[7:0];
    end
    if (rd_low) begin
      last_q <= mem[lat_lo];
    end
  end

  // Strobe edge counters and strobe length
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_q   <= 3'h0;
      strb_q   <= 4'h0;
      rd_cnt   <= 8'h00;
      wr_cnt   <= 8'h00;
      addr_latch_cnt <= 8'h00;
    end else begin
      prev_q   <= {addr_latch_strobe, wr_low, rd_low};
      strb_q   <= (rd_low | wr_low) ? strb_q + 4'h1 : 4'h0;
      rd_cnt   <= rd_cnt + 8'(rd_low & ~prev_q[0]);
      wr_cnt   <= wr_cnt + 8'(wr_low & ~prev_q[1]);
      addr_latch_cnt <= addr_latch_cnt + 8'(addr_latch_strobe & ~prev_q[2]);
    end
  end

  // Released data lines show the inverse of the last value, never a stale match
  // Wait pin is pulled up; code F holds it low to probe internal cycles
  always_comb begin
    pad_in    = '0;
    pad_in.p4 = rd_low ? mem[lat_lo] : ~last_q;
    pad_in.p6[ebi_pkg::P6_WAIT_INPUT] = ~(((rd_low | wr_low) && (strb_q < wait_cycles)) || (wait_cycles == 4'hF));
  end
endmodule : ebi_ext_mem
`default_nettype wire

// File: sim/ebi_bus_test.sv
// Self-checking bench for the external bus block and its memory model.
// Assumes the CPU request handshake and register map of the package.
`timescale 1ns/1ps
`default_nettype none
module ebi_bus_test;
  logic               ref_clk, rst, cpu_req, cpu_we, cpu_bit_op, cpu_int_hit;
  logic               main_crystal_clock, cpu_ready, cpu_done;
  logic [15:0]        cpu_addr;
  logic [2:0]         cpu_bit_sel;
  logic [7:0]         cpu_wdata, cpu_rdata_q, rd, rc, ra;
  logic [7:0]         lat_lo, lat_hi, lat_hi_oe, rd_cnt, wr_cnt, addr_latch_cnt;
  logic [3:0]         wait_cycles;
  logic [23:0]        pad_out, pad_oe;
  ebi_pkg::ebi_pins_t port_out, port_oe, pad_in;
  logic [2:0]         wins [4] = '{3'h3, 3'h4, 3'h5, 3'h7};
  logic [7:0]         msks [4] = '{8'h00, 8'h0F, 8'h3F, 8'hFF};
  int                 fails, num_checks, cyc, n;

  ebi_bus i_ebi_bus (.ref_clk(ref_clk), .rst(rst), .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_we(cpu_we),
    .cpu_bit_op(cpu_bit_op), .cpu_bit_sel(cpu_bit_sel), .cpu_wdata(cpu_wdata), .cpu_int_hit(cpu_int_hit),
    .main_crystal_clock(main_crystal_clock), .cpu_ready(cpu_ready), .cpu_done(cpu_done),
    .cpu_rdata_q(cpu_rdata_q), .port_out(port_out), .port_oe(port_oe), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe));
  ebi_ext_mem i_ebi_ext_mem (.ref_clk(ref_clk), .rst(rst), .pad_out(pad_out), .pad_oe(pad_oe),
    .wait_cycles(wait_cycles), .pad_in(pad_in), .lat_lo(lat_lo), .lat_hi(lat_hi), .lat_hi_oe(lat_hi_oe),
    .rd_cnt(rd_cnt), .wr_cnt(wr_cnt), .addr_latch_cnt(addr_latch_cnt));

  // Clock at 40 MHz
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task check(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One bus cycle: held until taken, then counted in cycles up to cpu_done
  task acc(input logic [15:0] a, input logic we, input logic [7:0] d, input logic ih, input logic bo,
           input logic [2:0] bs);
    @(posedge ref_clk);
    cpu_req     <= 1'b1;
    cpu_addr    <= a;
    cpu_we      <= we;
    cpu_wdata   <= d;
    cpu_int_hit <= ih;
    cpu_bit_op  <= bo;
    cpu_bit_sel <= bs;
    @(negedge ref_clk);
    while (cpu_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    cpu_req <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (cpu_done !== 1'b1 && n < 20);
    rd = cpu_rdata_q;
  endtask : acc

  task test_done;
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // Hang guard: the whole sequence needs about 140 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    {rst, cpu_req, cpu_addr, cpu_we, cpu_bit_op, cpu_bit_sel, cpu_wdata, cpu_int_hit} = '1;
    {cpu_req, cpu_we, cpu_bit_op, cpu_int_hit} = '0;
    main_crystal_clock = 1'b1;
    port_out           = 24'h5AA55A;
    port_oe            = 24'h400000;
    wait_cycles        = 4'h2;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    acc(16'hFF47, 1'b0, 8'h00, 1'b1, 1'b0, 3'h0);
    check(rd, ebi_pkg::EXPANSION_MODE_RST);
    acc(16'hFFF8, 1'b0, 8'h00, 1'b1, 1'b0, 3'h0);
    check(rd, ebi_pkg::WAIT_SETTING_RST);
    // Byte write keeps only the code, bit write clears one bit
    acc(16'hFF47, 1'b1, 8'hFF, 1'b1, 1'b0, 3'h0);
    acc(16'hFF47, 1'b0, 8'h00, 1'b1, 1'b0, 3'h0);
    check(rd, 8'h07);
    acc(16'hFF47, 1'b1, 8'h00, 1'b1, 1'b1, 3'h1);
    acc(16'hFF47, 1'b0, 8'h00, 1'b1, 1'b0, 3'h0);
    check(rd, 8'h05);
    acc(16'h6A5C, 1'b0, 8'h00, 1'b0, 1'b0, 3'h0);
    check(24'(n), 24'd4);
    // Prohibited wait code behaves as one wait
    acc(16'hFFF8, 1'b1, 8'h20, 1'b1, 1'b0, 3'h0);
    acc(16'h6A5C, 1'b0, 8'h00, 1'b0, 1'b0, 3'h0);
    check(24'(n), 24'd4);
    acc(16'hFFF8, 1'b1, 8'h00, 1'b1, 1'b0, 3'h0);
    // Every window: pins driven, masked upper address, data round trip
    for (int i = 0; i < 4; i++) begin
      acc(16'hFF47, 1'b1, {5'h00, wins[i]}, 1'b1, 1'b0, 3'h0);
      rc = wr_cnt;
      acc(16'h6A5C, 1'b1, 8'h30 + 8'(i), 1'b0, 1'b0, 3'h0);
      check(24'(n), 24'd3);
      check(wr_cnt, 8'(rc + 8'h01));
      check(lat_lo, 8'h5C);
      check(lat_hi_oe, msks[i]);
      check(lat_hi & msks[i], 8'h6A & msks[i]);
      acc(16'h6A5C, 1'b0, 8'h00, 1'b0, 1'b0, 3'h0);
      check(rd, 8'h30 + 8'(i));
    end
    // Internal cycle: address strobe only
    rc = rd_cnt;
    ra = addr_latch_cnt;
    acc(16'h6A5C, 1'b0, 8'h00, 1'b1, 1'b0, 3'h0);
    check(rd_cnt, rc);
    check(addr_latch_cnt, 8'(ra + 8'h01));
    // Pin wait stretches external cycles only
    acc(16'hFFF8, 1'b1, 8'h30, 1'b1, 1'b0, 3'h0);
    check(pad_oe[22], 1'b0);
    acc(16'h6A5C, 1'b0, 8'h00, 1'b0, 1'b0, 3'h0);
    check(24'(n), 24'(3 + wait_cycles));
    check(rd, 8'h33);
    wait_cycles = 4'hF;
    acc(16'h6A5C, 1'b0, 8'h00, 1'b1, 1'b0, 3'h0);
    check(24'(n), 24'd3);
    wait_cycles = 4'h2;
    acc(16'hFFF8, 1'b1, 8'h00, 1'b1, 1'b0, 3'h0);
    check(pad_oe[22], 1'b1);
    // Other CPU clock: no external strobe, pins handed back to the port
    @(posedge ref_clk);
    main_crystal_clock <= 1'b0;
    rc = rd_cnt;
    acc(16'h6A5C, 1'b0, 8'h00, 1'b0, 1'b0, 3'h0);
    check(rd_cnt, rc);
    check(pad_oe, port_oe);
    @(posedge ref_clk);
    main_crystal_clock <= 1'b1;
    // Single-chip and a prohibited code leave every pin a port
    for (int i = 0; i < 2; i++) begin
      acc(16'hFF47, 1'b1, 8'(i), 1'b1, 1'b0, 3'h0);
      rc = rd_cnt;
      acc(16'h6A5C, 1'b0, 8'h00, 1'b0, 1'b0, 3'h0);
      check(rd_cnt, rc);
      check(pad_oe, port_oe);
    end
    test_done();
  end
endmodule : ebi_bus_test
`default_nettype wire
